// ### aesr_pkg.sv
// Constants shared by the accelerometer error/status reporter.
// Assumes a 10 MHz core clock; the serial input pins cs_n, sclk and mosi are asynchronous to it.
package aesr_pkg;

  // Frame layout
  localparam int          FRAME_BITS   = 16;
  localparam logic [4:0]  FRAME_CNT    = 5'h10;
  localparam int          CMD_B15      = 15;
  localparam int          CMD_B14      = 14;
  localparam int          CMD_ACC      = 13;
  localparam int          PAR_BIT      = 12;
  localparam int          ADDR_HI      = 12;
  localparam int          ADDR_LO      = 8;
  localparam logic [1:0]  OP_NONE      = 2'h0;
  localparam logic [1:0]  OP_WRITE     = 2'h1;
  localparam logic [1:0]  OP_READ      = 2'h2;
  localparam logic [1:0]  OP_TEST      = 2'h3;
  localparam logic [1:0]  STS_ACCEL    = 2'h1;
  localparam logic [1:0]  STS_ERROR    = 2'h3;

  // Register addresses and fields
  localparam logic [4:0]  CTRL_ADDR    = 5'h01;
  localparam logic [4:0]  STAT_ADDR    = 5'h02;
  localparam int          CTRL_CE_BIT  = 4;
  localparam logic [7:0]  CTRL_RST_VAL = 8'h00;
  localparam logic [7:0]  CTRL_WR_MASK = 8'hef;

  // Error flag positions in the ten data bits of an error frame
  localparam int          FLG_DATA     = 9;
  localparam int          FLG_RESET_OCCURRED_FLAG   = 8;
  localparam int          FLG_INIT     = 7;
  localparam int          FLG_TEMP     = 6;
  localparam int          FLG_OFFSET   = 5;
  localparam int          FLG_AXIS     = 4;
  localparam int          FLG_SPICLK   = 3;
  localparam int          FLG_REQ      = 2;

  // Signed 10-bit result codes
  localparam int          RAW_W        = 12;
  localparam logic signed [11:0] LIN_MAX = 12'sh1fc;
  localparam logic signed [11:0] LIN_MIN = -12'sh1fd;
  localparam logic [9:0]  CODE_OVR     = 10'h1fd;
  localparam logic [9:0]  CODE_OVF     = 10'h1fe;
  localparam logic [9:0]  CODE_UNDR    = 10'h202;
  localparam logic [9:0]  CODE_UNF     = 10'h201;

  // Timing
  localparam int          CLK_MHZ      = 10;
  localparam int          INIT_TIME_US = 3000;
  localparam int          HPF_TIME_US  = 200000;
  localparam int          INIT_CYC     = INIT_TIME_US * CLK_MHZ;
  localparam int          HPF_CYC      = HPF_TIME_US * CLK_MHZ;
  localparam int          INIT_CNT_W   = 22;

  // Offset monitor threshold: 10 percent of full scale
  localparam logic [9:0]  OFS_FULL     = 10'h3ff;
  localparam int          OFS_PCT      = 10;
  localparam logic [9:0]  OFS_LIMIT    = 10'((int'(OFS_FULL) * OFS_PCT) / 100);

  // Odd parity over the whole frame, placed at the parity bit
  function automatic logic [15:0] add_par(input logic [15:0] w);
    logic [15:0] r;
    r          = w;
    r[PAR_BIT] = 1'b0;
    r[PAR_BIT] = ~(^r);
    return r;
  endfunction

  // Error frame carrying exactly one flag
  function automatic logic [15:0] err_word(input int flg);
    logic [15:0] r;
    r        = 16'h0000;
    r[11:10] = STS_ERROR;
    r[flg]   = 1'b1;
    return add_par(r);
  endfunction

endpackage

// ### aesr_sync.sv
// Two-stage synchroniser for a group of asynchronous pin inputs.
// Assumes the inputs are independent levels; no bus coherency is implied.
`timescale 1ns/100ps
module aesr_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else if (clk_en) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ### aesr_encode.sv
// Maps a raw signed filter result onto the signed 10-bit output code.
// Assumes the raw value and its overflow flag come from the core clock domain.
`timescale 1ns/100ps
module aesr_encode (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    clk_en,
  input  wire logic signed [11:0]      raw,
  input  wire logic                    ovf,
  output logic                   [9:0] signed_output_value
);
  logic [9:0] code_nxt;
  wire        pos_ovf = ovf & ~raw[11];
  wire        neg_ovf = ovf & raw[11];

  // Two's complement, bit 9 is the sign
  assign code_nxt = pos_ovf                  ? aesr_pkg::CODE_OVF :
                    neg_ovf                  ? aesr_pkg::CODE_UNF :
                    (raw > aesr_pkg::LIN_MAX) ? aesr_pkg::CODE_OVR :
                    (raw < aesr_pkg::LIN_MIN) ? aesr_pkg::CODE_UNDR :
                    raw[9:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      signed_output_value <= 10'h000;
    end else if (clk_en) begin
      signed_output_value <= code_nxt;
    end
  end
endmodule

// ### aesr_top.sv
// Serial-frame error detection, classification and reporting for a
// dual-axis accelerometer, with the signed 10-bit result encoding.
// Assumes cs_n, sclk and mosi arrive asynchronously from an external
// master; fault causes and results come from logic on clk.
`timescale 1ns/100ps

module aesr_top #(
  parameter int INIT_CYCLES = aesr_pkg::INIT_CYC,
  parameter int HPF_CYCLES  = aesr_pkg::HPF_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               clk_en,
  input  wire logic               cs_n,
  input  wire logic               sclk,
  input  wire logic               mosi,
  output logic                    miso,
  output logic                    miso_oe,
  input  wire logic signed [11:0] accel_x_raw,
  input  wire logic               accel_x_ovf,
  input  wire logic signed [11:0] accel_y_raw,
  input  wire logic               accel_y_ovf,
  input  wire logic               hpf_select,
  input  wire logic               offset_monitor_enable,
  input  wire logic        [9:0]  offset_monitor,
  input  wire logic        [7:0]  temp_reading,
  input  wire logic        [7:0]  temp_lo_limit,
  input  wire logic        [7:0]  temp_hi_limit,
  input  wire logic               parity_fault,
  input  wire logic               osc_fault,
  output logic             [7:0]  device_status_register,
  output logic             [7:0]  device_control_register,
  output logic                    reset_occurred_flag,
  output logic                    init_active
);

  typedef enum logic {AESR_IDLE, AESR_FRAME} aesr_state_t;

  aesr_state_t state_r;
  logic [2:0]  pins_s;
  logic        cs_d_r;
  logic        sclk_d_r;
  logic [15:0] rx_r;
  logic [15:0] tx_r;
  logic [15:0] resp_r;
  logic [15:0] resp_nxt;
  logic [4:0]  edge_cnt_r;
  logic        hi_at_sel_r;
  logic        first_r;
  logic        data_err_r;
  logic        temp_flag_r;
  logic        ofs_flag_r;
  logic [aesr_pkg::INIT_CNT_W-1:0] init_cnt_r;
  logic [9:0]  value;

  aesr_sync #(
    .W (3)
  ) u_sync (
    .clk    (clk),
    .rst    (rst),
    .clk_en (clk_en),
    .d      ({~cs_n, sclk, mosi}),
    .q      (pins_s)
  );

  // Select travels inverted so a flushed synchroniser reads as idle
  wire cs_s   = ~pins_s[2];
  wire sclk_s = pins_s[1];
  wire mosi_s = pins_s[0];

  // Edges seen on the synchronised pins
  wire sel_start = cs_d_r & ~cs_s;
  wire sel_end   = ~cs_d_r & cs_s;
  wire sck_rise  = ~cs_s & ~sclk_d_r & sclk_s;
  wire sck_fall  = ~cs_s & sclk_d_r & ~sclk_s;
  wire frame_end = (state_r == AESR_FRAME) & sel_end;

  // Command decode of the frame just received
  wire [1:0] op       = rx_r[aesr_pkg::CMD_B15:aesr_pkg::CMD_B14];
  wire       is_acc   = rx_r[aesr_pkg::CMD_ACC];
  wire       axis_sel = rx_r[aesr_pkg::CMD_B14];
  wire [4:0] addr     = rx_r[aesr_pkg::ADDR_HI:aesr_pkg::ADDR_LO];
  wire [7:0] wdata    = rx_r[7:0];

  wire spi_err  = (edge_cnt_r != aesr_pkg::FRAME_CNT) | hi_at_sel_r;
  wire axis_err = is_acc & rx_r[aesr_pkg::CMD_B15];
  wire req_err  = ~is_acc & ((op == aesr_pkg::OP_NONE) |
                  ((op == aesr_pkg::OP_WRITE) & (addr != aesr_pkg::CTRL_ADDR)));
  wire wr_ok    = ~spi_err & ~is_acc & (op == aesr_pkg::OP_WRITE) &
                  (addr == aesr_pkg::CTRL_ADDR);
  wire clr_err  = frame_end & wr_ok & wdata[aesr_pkg::CTRL_CE_BIT];

  // Fault causes
  wire temp_cause = (temp_reading > temp_hi_limit) |
                    (temp_reading < temp_lo_limit);
  wire ofs_cause  = offset_monitor_enable &
                    (offset_monitor >= aesr_pkg::OFS_LIMIT);

  // Initialization length depends on the high-pass filter choice
  wire [aesr_pkg::INIT_CNT_W-1:0] init_len =
    aesr_pkg::INIT_CNT_W'(INIT_CYCLES) +
    (hpf_select ? aesr_pkg::INIT_CNT_W'(HPF_CYCLES) : '0);
  wire init_busy = init_cnt_r < init_len;

  aesr_encode u_encode (
    .clk                 (clk),
    .rst                 (rst),
    .clk_en              (clk_en),
    .raw                 (axis_sel ? accel_y_raw : accel_x_raw),
    .ovf                 (axis_sel ? accel_y_ovf : accel_x_ovf),
    .signed_output_value (value)
  );

  // Register read data
  wire [7:0] stat_val = {2'b00, osc_fault, data_err_r, ofs_flag_r,
                         temp_flag_r, init_busy, reset_occurred_flag};
  wire [7:0] rd_val   = (addr == aesr_pkg::STAT_ADDR) ? stat_val :
                        (addr == aesr_pkg::CTRL_ADDR) ? device_control_register :
                        8'h00;

  // Normal answers by command type
  wire [15:0] acc_word = aesr_pkg::add_par({2'b00, axis_sel, 1'b0,
                                            aesr_pkg::STS_ACCEL, value});
  wire [15:0] reg_word = (op == aesr_pkg::OP_TEST) ? {rx_r[15:8], stat_val} :
                         (op == aesr_pkg::OP_READ) ? {rx_r[15:8], rd_val} :
                         {rx_r[15:8], device_control_register};

  // Response selection; earlier lines win
  always_comb begin
    if (data_err_r) begin
      resp_nxt = aesr_pkg::err_word(aesr_pkg::FLG_DATA);
    end else if (first_r) begin
      resp_nxt = aesr_pkg::err_word(aesr_pkg::FLG_RESET_OCCURRED_FLAG);
    end else if (spi_err) begin
      resp_nxt = aesr_pkg::err_word(aesr_pkg::FLG_SPICLK);
    end else if (is_acc & init_busy) begin
      resp_nxt = aesr_pkg::err_word(aesr_pkg::FLG_INIT);
    end else if (is_acc & temp_flag_r) begin
      resp_nxt = aesr_pkg::err_word(aesr_pkg::FLG_TEMP);
    end else if (is_acc & ofs_flag_r) begin
      resp_nxt = aesr_pkg::err_word(aesr_pkg::FLG_OFFSET);
    end else if (axis_err) begin
      resp_nxt = aesr_pkg::err_word(aesr_pkg::FLG_AXIS);
    end else if (req_err) begin
      resp_nxt = aesr_pkg::err_word(aesr_pkg::FLG_REQ);
    end else if (is_acc) begin
      resp_nxt = acc_word;
    end else begin
      resp_nxt = reg_word;
    end
  end

  // Frame sequencing and serial shifting
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r     <= AESR_IDLE;
      cs_d_r      <= 1'b1;
      sclk_d_r    <= 1'b0;
      rx_r        <= 16'h0000;
      tx_r        <= 16'h0000;
      edge_cnt_r  <= 5'h00;
      hi_at_sel_r <= 1'b0;
    end else if (clk_en) begin
      cs_d_r   <= cs_s;
      sclk_d_r <= sclk_s;
      case (state_r)
        AESR_IDLE: begin
          if (sel_start) begin
            state_r     <= AESR_FRAME;
            tx_r        <= resp_r;
            edge_cnt_r  <= 5'h00;
            hi_at_sel_r <= sclk_s;
          end
        end
        AESR_FRAME: begin
          if (sel_end) begin
            state_r <= AESR_IDLE;
          end else begin
            if (sck_rise) begin
              rx_r <= {rx_r[14:0], mosi_s};
              if (edge_cnt_r != 5'h1f) begin
                edge_cnt_r <= edge_cnt_r + 5'h01;
              end
            end
            if (sck_fall) begin
              tx_r <= {tx_r[14:0], 1'b0};
            end
          end
        end
        default: state_r <= AESR_IDLE;
      endcase
    end
  end

  // Data output pin
  always_ff @(posedge clk) begin
    if (rst) begin
      miso    <= 1'b0;
      miso_oe <= 1'b0;
    end else if (clk_en) begin
      miso_oe <= ~cs_s;
      if (osc_fault) begin
        miso <= ~cs_s;
      end else if (sel_start) begin
        miso <= resp_r[15];
      end else if (sck_fall) begin
        miso <= tx_r[14];
      end
    end
  end

  // Response latched at the end of each frame, sent in the next one
  always_ff @(posedge clk) begin
    if (rst) begin
      resp_r  <= 16'h0000;
      first_r <= 1'b1;
    end else if (clk_en) begin
      if (frame_end) begin
        resp_r  <= resp_nxt;
        first_r <= 1'b0;
      end
    end
  end

  // Sticky fault flags
  always_ff @(posedge clk) begin
    if (rst) begin
      data_err_r  <= 1'b0;
      temp_flag_r <= 1'b0;
      ofs_flag_r  <= 1'b0;
    end else if (clk_en) begin
      data_err_r  <= data_err_r | parity_fault;
      temp_flag_r <= temp_cause | (temp_flag_r & ~clr_err);
      ofs_flag_r  <= ofs_cause | (ofs_flag_r & ~clr_err);
    end
  end

  // Reset-occurred flag and initialization timer
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_occurred_flag <= 1'b1;
      init_cnt_r          <= '0;
      init_active         <= 1'b1;
    end else if (clk_en) begin
      if (clr_err & ~init_busy) begin
        reset_occurred_flag <= 1'b0;
      end
      if (init_busy) begin
        init_cnt_r <= init_cnt_r + aesr_pkg::INIT_CNT_W'(1'b1);
      end
      init_active <= init_busy;
    end
  end

  // Control and status registers
  always_ff @(posedge clk) begin
    if (rst) begin
      device_control_register <= aesr_pkg::CTRL_RST_VAL;
      device_status_register  <= 8'h00;
    end else if (clk_en) begin
      if (frame_end & wr_ok) begin
        device_control_register <= wdata & aesr_pkg::CTRL_WR_MASK;
      end
      device_status_register <= stat_val;
    end
  end

endmodule

// ### aesr_top_assertions.sv
// Port-level checks for the accelerometer error/status reporter.
// Assumes clk_en stays high; bound into every aesr_top instance.
`timescale 1ns/100ps
module aesr_top_assertions #(
  parameter int INIT_CYCLES = 30000,
  parameter int HPF_CYCLES  = 2000000
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       cs_n,
  input wire logic       miso,
  input wire logic       miso_oe,
  input wire logic       hpf_select,
  input wire logic       parity_fault,
  input wire logic       osc_fault,
  input wire logic [7:0] device_status_register,
  input wire logic       reset_occurred_flag,
  input wire logic       init_active
);
  logic [22:0] icnt_r;
  logic [22:0] icnt_nxt;
  logic [22:0] lim;
  // Cycles spent in initialization since the last reset
  assign icnt_nxt = icnt_r + {22'h0, init_active};
  assign lim = 23'(hpf_select ? INIT_CYCLES + HPF_CYCLES : INIT_CYCLES);
  always_ff @(posedge clk) begin
    if (rst) icnt_r <= 23'h0;
    else icnt_r <= icnt_nxt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_oe_on_select: assert property ($fell(cs_n) |-> ##[1:6] miso_oe)
    else $error("miso_oe late after select");
  a_oe_on_release: assert property ($rose(cs_n) |-> ##[1:6] !miso_oe)
    else $error("miso_oe held after release");
  a_osc_drives_high: assert property ((osc_fault && miso_oe) [*3] |-> miso)
    else $error("miso not high under osc fault");
  a_data_err_sets: assert property ($rose(parity_fault) |-> ##[1:3] device_status_register[4])
    else $error("data error not flagged");
  a_data_err_holds: assert property (device_status_register[4] |=> device_status_register[4])
    else $error("data error dropped without reset");
  a_flag_on_exit: assert property ($fell(rst) |-> reset_occurred_flag && init_active)
    else $error("flag or init not set after reset");
  a_flag_in_status: assert property (reset_occurred_flag [*4] |-> device_status_register[0])
    else $error("status lacks reset flag");
  a_flag_kept_init: assert property ($fell(reset_occurred_flag) |-> !$past(init_active))
    else $error("reset flag cleared during init");
  a_init_length: assert property ($fell(init_active) |->
    icnt_r + 23'h4 >= lim && icnt_r <= lim + 23'h4)
    else $error("init period length wrong");
  a_init_once: assert property (!init_active |=> !init_active)
    else $error("init restarted without reset");
endmodule

bind aesr_top aesr_top_assertions #(
  .INIT_CYCLES(INIT_CYCLES),
  .HPF_CYCLES (HPF_CYCLES)
) chk_i (.clk, .rst, .cs_n, .miso, .miso_oe, .hpf_select, .parity_fault,
         .osc_fault, .device_status_register, .reset_occurred_flag, .init_active);

// ### aesr_host.sv
// SPI master model polling the reporter, one frame per xfer call.
// Assumes the caller spaces frames; sclk stands low between frames.
`timescale 1ns/100ps
module aesr_host (
  output logic      cs_n,
  output logic      sclk,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // Sends cmd MSB first over nb rising edges; first 16 miso bits return
  task automatic xfer(input logic [15:0] cmd, input int nb, output logic [15:0] resp);
    logic [15:0] sh;
    sh = cmd;
    resp = 16'h0000;
    #37 cs_n = 1'b0;
    #800;
    for (int i = 0; i < nb; i++) begin
      mosi = sh[15];
      sh = {sh[14:0], 1'b0};
      #400 sclk = 1'b1;
      #400 if (i < 16) resp = {resp[14:0], miso};
      sclk = 1'b0;
    end
    mosi = ~mosi;
    #400 cs_n = 1'b1;
    #800;
  endtask
endmodule

// ### aesr_top_test.sv
// Self-checking bench for the accelerometer error/status reporter.
// Assumes aesr_host as serial master and a shortened init count.
`timescale 1ns/100ps
module aesr_top_test;
  localparam logic [15:0] ACCX = 16'h2000;
  localparam logic [15:0] ACCY = 16'h6000;
  localparam logic [15:0] RDCT = 16'h8100;
  localparam logic [15:0] TEST = 16'hc000;
  localparam logic [15:0] CEWR = 16'h4110;
  logic               clk;
  logic               rst;
  logic               cs_n;
  logic               sclk;
  logic               mosi;
  logic               miso;
  logic signed [11:0] rx;
  logic signed [11:0] ry;
  logic               ox;
  logic               oy;
  logic               ofs_en;
  logic        [9:0]  ofs;
  logic        [7:0]  temp;
  logic               par_f;
  logic               osc_f;
  logic        [7:0]  stat;
  logic        [7:0]  ctrl;
  logic               hpf;
  logic               rflag;
  logic               init;
  logic        [15:0] pend;
  logic               pend_v;
  string              pnm;
  int                 err_total;
  int                 n_tests;
  int                 cyc;

  aesr_top #(.INIT_CYCLES(2000), .HPF_CYCLES(300)) dut (
    .clk(clk), .rst(rst), .clk_en(1'b1), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
    .miso(miso), .miso_oe(), .accel_x_raw(rx), .accel_x_ovf(ox), .accel_y_raw(ry),
    .accel_y_ovf(oy), .hpf_select(hpf), .offset_monitor_enable(ofs_en),
    .offset_monitor(ofs), .temp_reading(temp), .temp_lo_limit(8'h10),
    .temp_hi_limit(8'h80), .parity_fault(par_f), .osc_fault(osc_f),
    .device_status_register(stat), .device_control_register(ctrl),
    .reset_occurred_flag(rflag), .init_active(init));
  aesr_host host (.cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso));

  function automatic logic [15:0] ew(input int f);
    logic [15:0] r;
    r = 16'h0c00;
    r[f] = 1'b1;
    r[12] = ~(^r);
    return r;
  endfunction
  function automatic logic [15:0] aw(input logic ax, input logic [9:0] c);
    logic [15:0] r;
    r = {2'b00, ax, 1'b0, 2'b01, c};
    r[12] = ~(^r);
    return r;
  endfunction
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One frame: judges the answer to the previous command if nb is at least 16, records the next
  task automatic fr(input string nm, input logic [15:0] cmd, input int nb,
                    input logic [15:0] nxt);
    logic [15:0] r;
    host.xfer(cmd, nb, r);
    if (pend_v && nb >= 16) chk(pnm, pend, r);
    pend = nxt;
    pnm = nm;
    pend_v = 1'b1;
    @(posedge clk);
    #1;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic t_init();
    chk("reset flag", 16'h1, {15'h0, rflag});
    fr("first", ACCX, 16, ew(aesr_pkg::FLG_RESET_OCCURRED_FLAG));
    fr("second", ACCX, 16, ew(aesr_pkg::FLG_INIT));
    fr("read", RDCT, 16, {RDCT[15:8], 8'h00});
    fr("test", TEST, 16, {TEST[15:8], 8'h03});
    fr("early ce", CEWR, 16, {CEWR[15:8], 8'h00});
    chk("flag kept", 16'h1, {15'h0, rflag});
    for (int i = 0; i < 3000 && init !== 1'b0; i++) @(posedge clk);
    #1 chk("init done", 16'h0, {15'h0, init});
    fr("late ce", CEWR, 16, {CEWR[15:8], 8'h00});
    chk("flag cleared", 16'h0, {15'h0, rflag});
    $display("test init done");
  endtask
  task automatic t_codes();
    logic signed [11:0] v [8] = '{12'sh1fc, -12'sh1fd, 12'sh1fd, -12'sh1fe,
                                  12'sh7ff, -12'sh800, 12'sh258, -12'sh258};
    logic [9:0] c [8] = '{10'h1fc, 10'h203, 10'h1fd, 10'h202,
                          10'h1fd, 10'h202, 10'h1fe, 10'h201};
    for (int i = 0; i < 8; i++) begin
      rx = i[0] ? 12'sh000 : v[i];
      ry = i[0] ? v[i] : 12'sh000;
      ox = (i > 5) && !i[0];
      oy = (i > 5) && i[0];
      fr("code", i[0] ? ACCY : ACCX, 16, aw(i[0], c[i]));
    end
    $display("test codes done");
  endtask
  task automatic t_transient();
    temp = 8'h08;
    fr("temp low", ACCX, 16, ew(aesr_pkg::FLG_TEMP));
    temp = 8'h90;
    fr("ce", CEWR, 16, {CEWR[15:8], 8'h00});
    fr("temp again", ACCX, 16, ew(aesr_pkg::FLG_TEMP));
    ofs = 10'h066;
    ofs_en = 1'b1;
    fr("priority", ACCX, 16, ew(aesr_pkg::FLG_TEMP));
    temp = 8'h40;
    fr("ce", CEWR, 16, {CEWR[15:8], 8'h00});
    fr("offset", ACCX, 16, ew(aesr_pkg::FLG_OFFSET));
    ofs = 10'h065;
    fr("ce", CEWR, 16, {CEWR[15:8], 8'h00});
    fr("below", ACCX, 16, aw(1'b0, 10'h000));
    ofs = 10'h066;
    ofs_en = 1'b0;
    fr("disabled", ACCX, 16, aw(1'b0, 10'h000));
    $display("test transient done");
  endtask
  task automatic t_external();
    fr("axis", 16'ha000, 16, ew(aesr_pkg::FLG_AXIS));
    fr("once", ACCX, 16, aw(1'b0, 10'h000));
    fr("no op", 16'h0000, 16, ew(aesr_pkg::FLG_REQ));
    fr("bad addr", 16'h4210, 16, ew(aesr_pkg::FLG_REQ));
    fr("plain", ACCX, 16, aw(1'b0, 10'h000));
    fr("short", ACCX, 15, ew(aesr_pkg::FLG_SPICLK));
    fr("long", ACCX, 17, ew(aesr_pkg::FLG_SPICLK));
    // Clock already high when select falls; 16 rises follow
    host.sclk = 1'b1;
    fr("high sel", ACCX, 17, ew(aesr_pkg::FLG_SPICLK));
    fr("after", ACCX, 16, aw(1'b0, 10'h000));
    fr("ctrl wr", 16'h41ff, 16, {8'h41, 8'h00});
    chk("ctrl", {8'h00, aesr_pkg::CTRL_WR_MASK}, {8'h00, ctrl});
    fr("ctrl rd", RDCT, 16, {RDCT[15:8], aesr_pkg::CTRL_WR_MASK});
    fr("tail", TEST, 16, {TEST[15:8], 8'h00});
    $display("test external done");
  endtask
  task automatic t_critical();
    logic [15:0] r;
    osc_f = 1'b1;
    host.xfer(TEST, 16, r);
    chk("osc", 16'hffff, r);
    @(posedge clk);
    #1 osc_f = 1'b0;
    par_f = 1'b1;
    pend_v = 1'b0;
    @(posedge clk);
    #1 par_f = 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("data err", 16'h1, {15'h0, stat[4]});
    fr("read", RDCT, 16, ew(aesr_pkg::FLG_DATA));
    fr("accel", ACCX, 16, ew(aesr_pkg::FLG_DATA));
    fr("test", TEST, 16, ew(aesr_pkg::FLG_DATA));
    fr("end", TEST, 16, 16'h0000);
    rst = 1'b1;
    hpf = 1'b1;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("recovered", 16'h0, {15'h0, stat[4]});
    chk("flag again", 16'h1, {15'h0, rflag});
    chk("ctrl reset", 16'h0, {8'h00, ctrl});
    // Filter selected: init lasts INIT_CYCLES plus HPF_CYCLES (2300 here)
    repeat (2200) @(posedge clk);
    #1 chk("hpf init on", 16'h1, {15'h0, init});
    repeat (110) @(posedge clk);
    #1 chk("hpf init off", 16'h0, {15'h0, init});
    $display("test critical done");
  endtask

  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      final_report();
    end
  end
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    rx = 12'sh000;
    ry = 12'sh000;
    ox = 1'b0;
    oy = 1'b0;
    ofs_en = 1'b0;
    ofs = 10'h000;
    temp = 8'h40;
    par_f = 1'b0;
    osc_f = 1'b0;
    hpf = 1'b0;
    pend_v = 1'b0;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge clk);
    #1 t_init();
    t_codes();
    t_transient();
    t_external();
    t_critical();
    final_report();
  end
endmodule
